// ===== core/volt_det_pkg.sv
`default_nettype none
package volt_det_pkg;

	// ----------------------------------------------------------------
	// Bus shape
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 12;

	// ----------------------------------------------------------------
	// Register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CTRL0  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CTRL1  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;

	localparam logic [DATA_W-1:0] CTRL0_RST  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] CTRL1_RST  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] READ_NONE  = 32'h0000_0000;

	// Reserved bits are never stored, so they always read back as zero
	localparam logic [DATA_W-1:0] CTRL0_MASK = 32'h0000_02FF;
	localparam logic [DATA_W-1:0] CTRL1_MASK = 32'h0000_00FF;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int C0_EN_BIT     = 0;
	localparam int C0_ACTION_BIT = 1;
	localparam int C0_SRC_LO     = 2;
	localparam int C0_SRC_HI     = 3;
	localparam int C0_TH_LO      = 4;
	localparam int C0_TH_HI      = 7;
	localparam int C0_IRQEN_BIT  = 9;

	localparam int C1_FILTER_ENABLE_BIT  = 0;
	localparam int C1_WID_LO     = 1;
	localparam int C1_WID_HI     = 3;
	localparam int C1_FCLK_BIT   = 4;
	localparam int C1_FALLOUT_BIT = 5;
	localparam int C1_RISEOUT_BIT = 6;
	localparam int C1_LEVEL_BIT  = 7;

	localparam int ST_FLAG_BIT   = 0;
	localparam int ST_LEVEL_BIT  = 1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_SUPPLY    = 2'b00,
		SRC_EXT_ONE   = 2'b01,
		SRC_EXT_TWO   = 2'b10,
		SRC_EXT_THREE = 2'b11
	} source_t;

	typedef enum logic [2:0] {
		WID_1    = 3'b000,
		WID_3    = 3'b001,
		WID_5    = 3'b010,
		WID_15   = 3'b011,
		WID_63   = 3'b100,
		WID_255  = 3'b101,
		WID_1023 = 3'b110,
		WID_4095 = 3'b111
	} width_code_t;

	// Filter clocks a level must hold before the output follows it
	function automatic logic [CNT_W-1:0] filter_limit(input width_code_t code);
		case (code)
			WID_1:    filter_limit = 12'h001;
			WID_3:    filter_limit = 12'h003;
			WID_5:    filter_limit = 12'h005;
			WID_15:   filter_limit = 12'h00F;
			WID_63:   filter_limit = 12'h03F;
			WID_255:  filter_limit = 12'h0FF;
			WID_1023: filter_limit = 12'h3FF;
			default:  filter_limit = 12'hFFF;
		endcase
	endfunction

endpackage
`default_nettype wire

// ===== core/glitch_filter.sv
`default_nettype none
module glitch_filter (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic                      sample_in,
	input  wire logic                      tick,
	input  wire logic                      filter_enable,
	input  wire volt_det_pkg::width_code_t filter_width_select,
	output logic                           filtered_level
);
	import volt_det_pkg::*;

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_inc;
	logic [CNT_W-1:0] limit;
	logic             reach;

	assign limit   = filter_limit(filter_width_select);
	assign cnt_inc = cnt_q + 12'h001;
	assign reach   = (cnt_inc >= limit);

	// ----------------------------------------------------------------
	// Width counter and output
	// ----------------------------------------------------------------
	// bypass when disabled
	// short pulses dropped
	// A change of level restarts the count, so only a steady run passes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q          <= 12'h000;
			filtered_level <= 1'b0;
		end else if (!filter_enable) begin
			cnt_q          <= 12'h000;
			filtered_level <= sample_in;
		end else if (sample_in == filtered_level) begin
			cnt_q <= 12'h000;
		end else if (tick) begin
			if (reach) begin
				cnt_q          <= 12'h000;
				filtered_level <= sample_in;
			end else begin
				cnt_q <= cnt_inc;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_filter_bypass: assert property (@(posedge clk) disable iff (!nrst)
		!filter_enable |=> filtered_level == $past(sample_in))
		else $error("bypassed filter did not follow its input");

	a_filter_hold: assert property (@(posedge clk) disable iff (!nrst)
		($past(filter_enable) && filter_enable && $changed(filtered_level))
		|-> ($past(tick) && $past(reach)))
		else $error("filter output moved before the width was reached");

endmodule
`default_nettype wire

// ===== core/volt_det_ctrl.sv
// Added by the designer: the strobed register port.
`default_nettype none
// Notes on behaviour
// - Interrupt enable gates any detector interrupt
// - Threshold code driven to threshold generator
// - Source select: supply or three pins
// - Action bit picks interrupt or reset
// - Detector disabled yields no trigger, flag, interrupt or reset
// - Level trigger while filtered output high
// - Trigger on comparator rising edge
// - Trigger on comparator falling edge
// - Filter clock: slow RC or fast oscillator
// - Width code sets rejected pulse length
// - Filter enable inserts filter before triggers
// - Status shows filtered level, read only
// - Flag reads set, write zero clears
// - Registers reset zero, reserved read zero
// - Hardware sets flag on enabled trigger with interrupt enable set, in interrupt mode
// - Interrupt or reset, never both
// - Pulses under width are suppressed
module volt_det_ctrl (
	input  wire logic                                clk,
	input  wire logic                                nrst,
	input  wire logic [volt_det_pkg::ADDR_W-1:0]     bus_addr,
	input  wire logic [volt_det_pkg::DATA_W-1:0]     bus_wdata,
	input  wire logic                                bus_wr,
	input  wire logic                                bus_rd,
	output logic      [volt_det_pkg::DATA_W-1:0]     bus_rdata,
	input  wire logic                                comp_out,
	input  wire logic                                low_speed_osc,
	input  wire logic                                high_speed_internal_osc,
	output logic      [3:0]                          threshold_code,
	output volt_det_pkg::source_t                    source_select,
	output logic                                     detector_enable,
	output logic                                     filtered_level,
	output logic                                     irq,
	output logic                                     reset_req
);
	import volt_det_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] ctrl0_q;
	logic [DATA_W-1:0] ctrl1_q;
	logic              irq_flag_q;
	logic              irq_flag_d;
	logic              reset_req_q;
	logic              prev_level_q;
	logic [1:0]        comp_sync_q;
	logic [2:0]        lso_sync_q;
	logic [2:0]        hso_sync_q;
	logic              comp_level;
	logic              filt_tick;
	logic              filt_out;
	logic              wr_ctrl0;
	logic              wr_ctrl1;
	logic              wr_status;
	logic              en;
	logic              action_reset;
	logic              irq_enable;
	logic              level_en;
	logic              rise_en;
	logic              fall_en;
	logic              trig;
	logic              flag_set;
	logic              flag_clr;
	logic [DATA_W-1:0] rdata_d;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	always_comb begin
		wr_ctrl0  = 1'b0;
		wr_ctrl1  = 1'b0;
		wr_status = 1'b0;
		if (bus_wr && bus_addr == OFF_CTRL0) begin
			wr_ctrl0 = 1'b1;
		end else if (bus_wr && bus_addr == OFF_CTRL1) begin
			wr_ctrl1 = 1'b1;
		end else if (bus_wr && bus_addr == OFF_STATUS) begin
			wr_status = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// reset to zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl0_q <= CTRL0_RST;
		end else if (wr_ctrl0) begin
			ctrl0_q <= bus_wdata & CTRL0_MASK;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl1_q <= CTRL1_RST;
		end else if (wr_ctrl1) begin
			ctrl1_q <= bus_wdata & CTRL1_MASK;
		end
	end

	assign en           = ctrl0_q[C0_EN_BIT];
	assign action_reset = ctrl0_q[C0_ACTION_BIT];
	assign irq_enable   = ctrl0_q[C0_IRQEN_BIT];
	assign level_en     = ctrl1_q[C1_LEVEL_BIT];
	assign rise_en      = ctrl1_q[C1_RISEOUT_BIT];
	assign fall_en      = ctrl1_q[C1_FALLOUT_BIT];

	// ----------------------------------------------------------------
	// Analog side controls
	// ----------------------------------------------------------------
	// threshold code out
	assign threshold_code  = ctrl0_q[C0_TH_HI:C0_TH_LO];
	assign source_select   = source_t'(ctrl0_q[C0_SRC_HI:C0_SRC_LO]);
	assign detector_enable = en;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Third stage only serves edge detection on the oscillator inputs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			comp_sync_q <= 2'b00;
			lso_sync_q  <= 3'b000;
			hso_sync_q  <= 3'b000;
		end else begin
			comp_sync_q <= {comp_sync_q[0], comp_out};
			lso_sync_q  <= {lso_sync_q[1:0], low_speed_osc};
			hso_sync_q  <= {hso_sync_q[1:0], high_speed_internal_osc};
		end
	end

	assign comp_level = comp_sync_q[1];

	// filter clock choice
	// The fast oscillator is only seen as fast as this clock samples it,
	// so at high rates the tick rate saturates near half the bus clock
	assign filt_tick = ctrl1_q[C1_FCLK_BIT] ? (hso_sync_q[1] & ~hso_sync_q[2])
	                                        : (lso_sync_q[1] & ~lso_sync_q[2]);

	// ----------------------------------------------------------------
	// Digital filter
	// ----------------------------------------------------------------
	// filter ahead of triggers
	glitch_filter u_filter (
		.clk                 (clk),
		.nrst                (nrst),
		.sample_in           (comp_level),
		.tick                (filt_tick),
		.filter_enable       (ctrl1_q[C1_FILTER_ENABLE_BIT]),
		.filter_width_select (width_code_t'(ctrl1_q[C1_WID_HI:C1_WID_LO])),
		.filtered_level      (filt_out)
	);

	assign filtered_level = filt_out;

	// ----------------------------------------------------------------
	// Trigger detection
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_level_q <= 1'b0;
		end else begin
			prev_level_q <= filt_out;
		end
	end

	assign trig = en & ((level_en & filt_out)
	                  | (rise_en & filt_out & ~prev_level_q)
	                  | (fall_en & ~filt_out & prev_level_q));

	// ----------------------------------------------------------------
	// Interrupt flag and outputs
	// ----------------------------------------------------------------
	// hardware sets flag
	assign flag_set = trig & irq_enable & ~action_reset;
	assign flag_clr = wr_status & ~bus_wdata[ST_FLAG_BIT];
	// A trigger in the clearing cycle wins, so no event is lost
	assign irq_flag_d = flag_set | (irq_flag_q & ~flag_clr);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_flag_q <= 1'b0;
		end else begin
			irq_flag_q <= irq_flag_d;
		end
	end

	// interrupt only in interrupt mode
	// A reset request left over from the old action setting masks the interrupt,
	// so a switch of action in mid-trigger cannot show both at once
	assign irq = irq_flag_q & irq_enable & en & ~action_reset & ~reset_req_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reset_req_q <= 1'b0;
		end else begin
			reset_req_q <= trig & action_reset;
		end
	end

	assign reset_req = reset_req_q;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// level read only
	always_comb begin
		rdata_d = READ_NONE;
		if (bus_addr == OFF_CTRL0) begin
			rdata_d = ctrl0_q;
		end else if (bus_addr == OFF_CTRL1) begin
			rdata_d = ctrl1_q;
		end else if (bus_addr == OFF_STATUS) begin
			rdata_d[ST_FLAG_BIT]  = irq_flag_q;
			rdata_d[ST_LEVEL_BIT] = filt_out;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bus_rdata <= READ_NONE;
		end else if (bus_rd) begin
			bus_rdata <= rdata_d;
		end else begin
			bus_rdata <= READ_NONE;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_irq_gated: assert property (@(posedge clk) disable iff (!nrst)
		!irq_enable |-> !irq)
		else $error("interrupt raised while disabled");

	a_threshold_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_ctrl0 |=> threshold_code == $past(bus_wdata[C0_TH_HI:C0_TH_LO]))
		else $error("threshold code not taken from write");

	a_source_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_ctrl0 |=> source_select == $past(bus_wdata[C0_SRC_HI:C0_SRC_LO]))
		else $error("source select not taken from write");

	a_off_quiet: assert property (@(posedge clk) disable iff (!nrst)
		!en |=> !reset_req && !$rose(irq_flag_q))
		else $error("disabled detector produced an event");

	a_never_both: assert property (@(posedge clk) disable iff (!nrst)
		!(irq && reset_req))
		else $error("interrupt and reset at once");

	a_level_reset: assert property (@(posedge clk) disable iff (!nrst)
		(en && action_reset && level_en && filt_out) |=> reset_req)
		else $error("level trigger missed");

	a_rise_flag: assert property (@(posedge clk) disable iff (!nrst)
		(en && irq_enable && !action_reset && rise_en && filt_out && !prev_level_q)
		|=> irq_flag_q)
		else $error("rising trigger missed");

	a_fall_flag: assert property (@(posedge clk) disable iff (!nrst)
		(en && irq_enable && !action_reset && fall_en && !filt_out && prev_level_q)
		|=> irq_flag_q)
		else $error("falling trigger missed");

	a_flag_keep: assert property (@(posedge clk) disable iff (!nrst)
		(irq_flag_q && !(wr_status && !bus_wdata[ST_FLAG_BIT])) |=> irq_flag_q)
		else $error("flag lost without a zero write");

	a_flag_clear: assert property (@(posedge clk) disable iff (!nrst)
		(wr_status && !bus_wdata[ST_FLAG_BIT] && !flag_set) |=> !irq_flag_q)
		else $error("zero write did not clear flag");

	a_status_read: assert property (@(posedge clk) disable iff (!nrst)
		(bus_rd && bus_addr == OFF_STATUS)
		|=> bus_rdata == {30'h0, $past(filt_out), $past(irq_flag_q)})
		else $error("status read mismatch");

	a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
		$past(bus_rd) && $past(bus_addr) == OFF_CTRL0 |-> (bus_rdata & ~CTRL0_MASK) == 32'h0)
		else $error("reserved bits read nonzero");

	a_irq_mode_quiet: assert property (@(posedge clk) disable iff (!nrst)
		!action_reset |=> !reset_req)
		else $error("reset request in interrupt mode");

	a_reset_no_flag: assert property (@(posedge clk) disable iff (!nrst)
		action_reset |=> !$rose(irq_flag_q))
		else $error("flag set in reset mode");

	a_flag_needs_enable: assert property (@(posedge clk) disable iff (!nrst)
		!irq_enable |=> !$rose(irq_flag_q))
		else $error("flag set with interrupt disabled");

endmodule
`default_nettype wire

// ===== tb/volt_comp_model.sv
`default_nettype none
module volt_comp_model (
	input  wire logic [3:0]            threshold_code,
	input  wire volt_det_pkg::source_t source_select,
	input  wire logic [3:0][11:0]      mv,
	output var  logic                  comp_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [11:0] th;
	logic [11:0] v;

	// ----------------------------------------------------------------
	// Comparator
	// ----------------------------------------------------------------
	// Code picks threshold
	assign th = 12'h708 + 12'h064 * threshold_code;
	assign v = mv[source_select];

	// Output holds inside the 40 mV band (20 mV either side of threshold), so a level near threshold cannot chatter
	initial comp_out = 1'b0;
	always @(th or v) begin
		if (v + 12'h014 < th)
			comp_out = 1'b1;
		else if (v > th + 12'h014)
			comp_out = 1'b0;
	end
endmodule
`default_nettype wire

// ===== tb/tb_low_voltage_detector_ctrl.sv
`default_nettype none
module tb_low_voltage_detector_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import volt_det_pkg::*;

	logic             clk;
	logic             nrst;
	logic [7:0]       bus_addr;
	logic [31:0]      bus_wdata;
	logic             bus_wr;
	logic             bus_rd;
	logic [31:0]      bus_rdata;
	logic             comp_out;
	logic             low_speed_osc = 1'b0;
	logic             high_speed_internal_osc = 1'b0;
	logic [2:0]       osc_cnt_q = 3'h0;
	logic [3:0]       threshold_code;
	source_t          source_select;
	logic             detector_enable;
	logic             filtered_level;
	logic             irq;
	logic             reset_req;
	logic [3:0][11:0] mv;
	logic [11:0]      lo;
	logic [11:0]      hi;
	int               n_errors = 0;
	int               compares = 0;

	volt_det_ctrl i_dut (.clk(clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .comp_out(comp_out),
		.low_speed_osc(low_speed_osc), .high_speed_internal_osc(high_speed_internal_osc),
		.threshold_code(threshold_code), .source_select(source_select),
		.detector_enable(detector_enable), .filtered_level(filtered_level), .irq(irq),
		.reset_req(reset_req));

	volt_comp_model i_comp (.threshold_code(threshold_code), .source_select(source_select),
		.mv(mv), .comp_out(comp_out));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Fast oscillator ticks every 4 clocks, slow one every 8
	always @(posedge clk) begin
		osc_cnt_q <= osc_cnt_q + 3'h1;
		high_speed_internal_osc <= osc_cnt_q[1];
		low_speed_osc <= osc_cnt_q[2];
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("Compares %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		check(bus_rdata & m, exp);
	endtask

	// Channel lo_ch sits below threshold, the rest above; -1 puts all above
	task automatic setv(input int lo_ch);
		@(posedge clk);
		for (int i = 0; i < 4; i++)
			mv[i] <= (i == lo_ch) ? lo : hi;
	endtask

	function automatic int ticks(input logic [2:0] c);
		case (c)
			3'h0: ticks = 1;
			3'h1: ticks = 3;
			3'h2: ticks = 5;
			3'h3: ticks = 15;
			3'h4: ticks = 63;
			3'h5: ticks = 255;
			3'h6: ticks = 1023;
			default: ticks = 4095;
		endcase
	endfunction

	// Pulse channel 0 low for len+1 clocks, let the filter settle, then read the flag
	task automatic pulse(input logic [31:0] c1, input int len, input logic exp);
		int n;
		int p;
		n = c1[0] ? ticks(c1[3:1]) : 0;
		p = c1[4] ? 4 : 8;
		wr(8'h04, c1);
		setv(0);
		cyc(len);
		setv(-1);
		cyc((n + 2) * p + 10);
		rd(8'h08, 32'hFFFF_FFFF, {31'h0, exp});
		check(filtered_level, 1'b0);
		wr(8'h08, 32'h0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d0;
		logic [31:0] d1;
		logic [3:0]  tc;
		logic [7:0]  c1_tab [3];
		int          lat;
		c1_tab = '{8'h40, 8'h20, 8'h60};
		nrst = 1'b0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		hi = 12'hDAC;
		lo = 12'h6A4;
		mv = {4{12'hDAC}};
		void'($urandom(6647));
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		rd(8'h00, 32'hFFFF_FFFF, 32'h0);
		rd(8'h04, 32'hFFFF_FFFF, 32'h0);
		rd(8'h08, 32'hFFFF_FFFF, 32'h0);
		rd(8'h0C, 32'hFFFF_FFFF, 32'h0);
		for (int k = 0; k < 6; k++) begin
			// Software keeps reserved bits at their default
			d0 = $urandom & CTRL0_MASK;
			d1 = $urandom & CTRL1_MASK;
			wr(8'h00, d0);
			wr(8'h04, d1);
			wr(8'h0C, ~d0);
			rd(8'h00, 32'hFFFF_FFFF, d0 & 32'h0000_02FF);
			rd(8'h04, 32'hFFFF_FFFF, d1 & 32'h0000_00FF);
			check(threshold_code, d0[7:4]);
			check(source_select, d0[3:2]);
			check(detector_enable, d0[0]);
		end
		wr(8'h08, 32'h0000_0001);
		rd(8'h08, 32'hFFFF_FFFF, 32'h0);
		// Level trigger at a random threshold
		tc = 4'($urandom_range(15, 0));
		lo = 12'h708 + 12'h064 * tc - 12'h01E;
		hi = 12'h708 + 12'h064 * tc + 12'h01E;
		wr(8'h04, 32'h80);
		wr(8'h00, 32'h201 | {24'h0, tc, 4'h0});
		setv(0);
		lat = 0;
		do begin
			@(posedge clk);
			#1;
			lat++;
		end while (irq !== 1'b1 && lat < 8);
		check(irq, 1'b1);
		check(filtered_level, 1'b1);
		if (irq !== 1'b1)
			conclude();
		rd(8'h08, 32'hFFFF_FFFF, 32'h3);
		wr(8'h08, 32'h1);
		rd(8'h08, 32'hFFFF_FFFF, 32'h3);
		setv(-1);
		cyc(8);
		wr(8'h08, 32'h0);
		rd(8'h08, 32'hFFFF_FFFF, 32'h0);
		check(irq, 1'b0);
		// Interrupt disabled, then detector disabled in reset mode
		for (int k = 0; k < 2; k++) begin
			wr(8'h00, (k ? 32'h202 : 32'h001) | {24'h0, tc, 4'h0});
			setv(0);
			cyc(8);
			check(irq, 1'b0);
			check(reset_req, 1'b0);
			rd(8'h08, 32'h1, 32'h0);
			setv(-1);
			cyc(8);
		end
		// Edge conditions and their combination
		for (int k = 0; k < 3; k++) begin
			wr(8'h04, {24'h0, c1_tab[k]});
			wr(8'h00, 32'h201 | {24'h0, tc, 4'h0});
			setv(0);
			cyc(8);
			rd(8'h08, 32'h1, {31'h0, 1'(3'b101 >> k)});
			wr(8'h08, 32'h0);
			setv(-1);
			cyc(8);
			rd(8'h08, 32'h1, {31'h0, 1'(3'b110 >> k)});
			wr(8'h08, 32'h0);
		end
		// Reset action for each monitored source
		wr(8'h04, 32'h80);
		for (int s = 0; s < 4; s++) begin
			wr(8'h00, 32'h203 | (s << 2) | {24'h0, tc, 4'h0});
			setv(s);
			cyc(8);
			check(reset_req, 1'b1);
			check(irq, 1'b0);
			rd(8'h08, 32'h1, 32'h0);
			setv((s + 1) % 4);
			cyc(8);
			check(reset_req, 1'b0);
		end
		// Filter widths; the slow clock case fails if fast ticks were counted
		lo = 12'h6A4;
		hi = 12'h76C;
		// All sources above threshold before the source switches back to channel 0
		setv(-1);
		wr(8'h00, 32'h201);
		pulse(32'h80, 1, 1'b1);
		for (int k = 0; k < 7; k++) begin
			if (ticks(3'(k)) > 1)
				pulse(32'h91 | (k << 1), (ticks(3'(k)) - 1) * 4 - 2, 1'b0);
			pulse(32'h91 | (k << 1), (ticks(3'(k)) + 1) * 4, 1'b1);
		end
		pulse(32'h83, 14, 1'b0);
		pulse(32'h83, 32, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire
